// *** hw/owc_osc_divider.sv ***
// oscillator pin synchroniser, source selector and three-stage divider
`timescale 1ns/1ps
module owc_osc_divider
  import owc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // raw oscillator outputs
  input wire logic fastClock,
  input wire logic slowClock,
  // tick to the counter
  owc_tick_if.gen tk
);
  typedef struct packed {
    logic [2:0] fSync;
    logic [2:0] sSync;
    logic [PRE_W-1:0] div;
    logic tick;
  } owc_div_t;

  owc_div_t q;
  owc_div_t next_q;
  logic fastEdge;
  logic slowEdge;
  logic srcEdge;

  function automatic logic [PRE_W-1:0] divMask(input logic [1:0] sel);
    case (sel)
      2'h0: divMask = 3'h0;
      2'h1: divMask = 3'h1;
      2'h2: divMask = 3'h3;
      default: divMask = 3'h7;
    endcase
  endfunction

  // edges are taken from the second and third stage only
  assign fastEdge = q.fSync[1] & ~q.fSync[2];
  assign slowEdge = q.sSync[1] & ~q.sSync[2];
  assign srcEdge = tk.src ? slowEdge : fastEdge;
  assign tk.tick = q.tick;

  always_comb
  begin
    next_q = q;
    next_q.fSync = {q.fSync[1:0], fastClock};
    next_q.sSync = {q.sSync[1:0], slowClock};
    next_q.tick = 1'b0;
    if (tk.clr)
    begin
      next_q.div = '0;
    end
    else if (srcEdge)
    begin
      next_q.tick = (q.div & divMask(tk.div)) == divMask(tk.div);
      next_q.div = q.div + 3'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= next_q;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_div_pass;
    (tk.div == 2'h0 && srcEdge && !tk.clr) |=> tk.tick;
  endproperty
  a_div_pass: assert property (p_div_pass) else $error("undivided edge gave no tick");

  property p_div_eight;
    (tk.div == 2'h3 && srcEdge && !tk.clr && q.div != 3'h7) |=> !tk.tick;
  endproperty
  a_div_eight: assert property (p_div_eight) else $error("divide by eight ticked early");
endmodule // owc_osc_divider

// *** hw/owc_pkg.sv ***
// shared constants and types of the oscillator warm-up counter
package owc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMP = 8'h04;
  localparam logic [7:0] OFF_OSC = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  // control register fields
  localparam int CTRL_SRC = 0;
  localparam int CTRL_DIV = 1;
  localparam int CTRL_ABORT = 3;
  // oscillator register fields
  localparam int OSC_FAST = 0;
  localparam int OSC_SLOW = 1;
  localparam int OSC_SYSCK = 2;
  // reset values
  localparam logic RST_SRC = 1'h0;
  localparam logic [1:0] RST_DIV = 2'h3;
  localparam logic [7:0] RST_CMP = 8'h66;
  // counter geometry
  localparam int CNT_W = 14;
  localparam int CMP_W = 8;
  localparam int PRE_W = 3;
  // ahb encodings
  localparam logic [2:0] BUS_WORD = 3'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RSTWU = 3'b001,
    ST_STOPWU = 3'b010,
    ST_SWWU = 3'b011
  } owc_state_t;
endpackage

// *** hw/owc_tick_if.sv ***
// carrier between warm-up control and the source divider
`timescale 1ns/1ps
interface owc_tick_if;
  logic src;
  logic [1:0] div;
  logic clr;
  logic tick;
  modport ctl (output src, output div, output clr, input tick);
  modport gen (input src, input div, input clr, output tick);
endinterface

// *** hw/owc_warmup_counter.sv ***
// oscillator warm-up counter with ahb-lite register slave
//
// Function
// - warm-up runs while cpu held in reset
// - reset selects fast clock divided by eight
// - after reset counter counts fast clock
// - reset warm-up match releases cpu reset
// - compare value resets to 0x66
// - stop release uses main clock source
// - stop warm-up match resumes execution
// - divide codes give 1, 2, 4, 8
// - source select: 0 fast, 1 slow
// - enable rising edge starts software warm-up
// - software match: interrupt, stop, clear counter
// - abort stops, clears, bit self-clears
// - abort keeps enables; restart needs clear first
// - stop during software warm-up holds count
// - selector, three-stage divider, fourteen-stage counter
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module owc_warmup_counter
  import owc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // raw oscillator outputs
  input wire logic fastClock,
  input wire logic slowClock,
  // operation mode control
  input wire logic stopMode,
  // reset, resume and oscillator control
  output logic periphResetN,
  output logic stopHold,
  output logic warmupDoneIrq,
  output logic fastOscEnable,
  output logic slowOscEnable
);
  typedef struct packed {
    owc_state_t st;
    logic [CNT_W-1:0] count;
    logic srcSel;
    logic [1:0] divSel;
    logic [CMP_W-1:0] cmp;
    logic fastEn;
    logic slowEn;
    logic sysck;
    logic swSrc;
    logic stopPrev;
    logic apValid;
    logic apWrite;
    logic [7:0] apAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic periphResetN;
    logic stopHold;
    logic irq;
    logic fastOut;
    logic slowOut;
  } owc_regs_t;

  owc_regs_t q;
  owc_regs_t next_q;
  owc_tick_if tk ();

  logic active;
  logic match;
  logic wrData;
  logic abortHit;
  logic oscRise;

  function automatic logic [31:0] regRead(input logic [7:0] a);
    case (a)
      OFF_CTRL: regRead = {29'h0, q.divSel, q.srcSel};
      OFF_CMP: regRead = {24'h0, q.cmp};
      OFF_OSC: regRead = {29'h0, q.sysck, q.slowEn, q.fastEn};
      OFF_STAT: regRead = {2'h0, q.count, 11'h0, q.stopHold, q.periphResetN, q.st};
      default: regRead = 32'h0;
    endcase
  endfunction

  owc_osc_divider u_div (
    .clock(clock),
    .rstn(rstn),
    .fastClock(fastClock),
    .slowClock(slowClock),
    .tk(tk)
  );

  // divider source: main clock after stop, chosen source in software mode
  assign tk.src = (q.st == ST_STOPWU) ? q.sysck :
                  (q.st == ST_SWWU) ? q.swSrc : 1'b0;
  assign tk.div = q.divSel;
  assign tk.clr = (q.st == ST_IDLE);

  assign active = (q.st != ST_IDLE) && !stopMode;
  assign match = active && (q.count[CNT_W-1 -: CMP_W] == q.cmp);
  assign wrData = q.apValid && q.apWrite;
  assign abortHit = wrData && (q.apAddr == OFF_CTRL) && hwdata[CTRL_ABORT]
                    && (q.st == ST_SWWU);
  assign oscRise = (hwdata[OSC_FAST] & ~q.fastEn) | (hwdata[OSC_SLOW] & ~q.slowEn);

  always_comb
  begin
    next_q = q;
    next_q.irq = 1'b0;
    next_q.stopPrev = stopMode;
    // oscillators stand still during stop
    next_q.fastOut = q.fastEn & ~stopMode;
    next_q.slowOut = q.slowEn & ~stopMode;
    if (active)
    begin
      if (match)
      begin
        next_q.count = '0;
        next_q.st = ST_IDLE;
        case (q.st)
          ST_RSTWU: next_q.periphResetN = 1'b1;
          ST_STOPWU: next_q.stopHold = 1'b0;
          ST_SWWU: next_q.irq = 1'b1;
          default: next_q.st = ST_IDLE;
        endcase
      end
      else if (tk.tick)
      begin
        next_q.count = q.count + 1'b1;
      end
    end
    // stop entered from idle arms a warm-up for its release
    if (stopMode && !q.stopPrev && q.st == ST_IDLE)
      next_q.stopHold = 1'b1;
    if (!stopMode && q.stopPrev && q.stopHold && q.st == ST_IDLE)
      next_q.st = ST_STOPWU;
    if (wrData)
    begin
      case (q.apAddr)
        OFF_CTRL:
        begin
          next_q.srcSel = hwdata[CTRL_SRC];
          next_q.divSel = hwdata[CTRL_DIV +: 2];
          if (abortHit)
          begin
            // abort wins over a match in the same cycle
            next_q.st = ST_IDLE;
            next_q.count = '0;
            next_q.irq = 1'b0;
          end
        end
        OFF_CMP: next_q.cmp = hwdata[CMP_W-1:0];
        OFF_OSC:
        begin
          next_q.fastEn = hwdata[OSC_FAST];
          next_q.slowEn = hwdata[OSC_SLOW];
          next_q.sysck = hwdata[OSC_SYSCK];
          if (oscRise && q.st == ST_IDLE && !q.stopHold && !stopMode)
          begin
            next_q.st = ST_SWWU;
            next_q.count = '0;
            next_q.swSrc = q.srcSel;
          end
        end
        default: next_q.apWrite = q.apWrite;
      endcase
    end
    // address phase, zero wait states
    next_q.apValid = hsel && htrans[1] && hready && (hsize == BUS_WORD);
    next_q.apWrite = hwrite;
    next_q.apAddr = haddr[7:0];
    next_q.hrdata = (next_q.apValid && !hwrite) ? regRead(haddr[7:0]) : 32'h0;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.st <= ST_RSTWU;
      q.srcSel <= RST_SRC;
      q.divSel <= RST_DIV;
      q.cmp <= RST_CMP;
      q.fastEn <= 1'b1;
      q.hreadyout <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign periphResetN = q.periphResetN;
  assign stopHold = q.stopHold;
  assign warmupDoneIrq = q.irq;
  assign fastOscEnable = q.fastOut;
  assign slowOscEnable = q.slowOut;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_stopRel;
    q.st == ST_IDLE && q.stopHold && q.stopPrev && !stopMode;
  endsequence

  sequence s_swStart;
    wrData && q.apAddr == OFF_OSC && oscRise && q.st == ST_IDLE
      && !q.stopHold && !stopMode;
  endsequence

  property p_rst_hold;
    q.st == ST_RSTWU |-> !periphResetN;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("cpu reset freed early");

  property p_rst_vals;
    $past(!rstn) |-> (q.divSel == 2'h3 && !q.srcSel && q.cmp == 8'h66 && q.st == ST_RSTWU);
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");

  property p_count_up;
    (active && tk.tick && !match && !wrData) |=> q.count == $past(q.count) + 14'h1;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter missed a tick");

  property p_rst_release;
    (q.st == ST_RSTWU && match) |=> (periphResetN && q.st == ST_IDLE);
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("reset warm-up end wrong");

  property p_stop_src;
    q.st == ST_STOPWU |-> tk.src == q.sysck;
  endproperty
  a_stop_src: assert property (p_stop_src) else $error("stop warm-up wrong source");

  property p_stop_wu;
    s_stopRel |=> (q.st == ST_STOPWU && stopHold && q.count == 14'h0);
  endproperty
  a_stop_wu: assert property (p_stop_wu) else $error("stop release gave no warm-up");

  property p_stop_end;
    (q.st == ST_STOPWU && match) |=> (!stopHold ##1 !stopHold);
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("resume not given");

  property p_sw_start;
    s_swStart |=> (q.st == ST_SWWU && q.count == 14'h0);
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("enable edge did not start");

  property p_no_restart;
    (wrData && q.apAddr == OFF_OSC && !oscRise && q.st == ST_IDLE) |=> q.st != ST_SWWU;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("rewrite of one restarted");

  property p_sw_done;
    (q.st == ST_SWWU && match && !abortHit) |=> (warmupDoneIrq && q.count == 14'h0 ##1 !warmupDoneIrq);
  endproperty
  a_sw_done: assert property (p_sw_done) else $error("software warm-up end wrong");

  property p_abort;
    abortHit |=> (q.st == ST_IDLE && q.count == 14'h0 && !warmupDoneIrq
      && q.fastEn == $past(q.fastEn) && q.slowEn == $past(q.slowEn));
  endproperty
  a_abort: assert property (p_abort) else $error("abort mishandled");

  property p_stop_hold_count;
    (q.st == ST_SWWU && stopMode && !wrData) |=> q.count == $past(q.count);
  endproperty
  a_stop_hold_count: assert property (p_stop_hold_count) else $error("count moved in stop");

  property p_idle_clear;
    q.st == ST_IDLE |-> q.count == 14'h0;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle counter not cleared");

  property p_irq_only_sw;
    warmupDoneIrq |-> $past(q.st) == ST_SWWU;
  endproperty
  a_irq_only_sw: assert property (p_irq_only_sw) else $error("stray interrupt");

  property p_sw_src;
    q.st == ST_SWWU |-> tk.src == q.swSrc;
  endproperty
  a_sw_src: assert property (p_sw_src) else $error("software warm-up wrong source");

  property p_cmp_write;
    (wrData && q.apAddr == OFF_CMP) |=> q.cmp == $past(hwdata[CMP_W-1:0]);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("compare value not stored");
endmodule // owc_warmup_counter

// *** tb/oscillator_warmup_counter_tb.sv ***
// self-checking bench of the oscillator warm-up counter
`timescale 1ns/1ps
module oscillator_warmup_counter_tb
  import owc_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = BUS_WORD;
  logic [31:0] hwdata = 32'h0;
  logic stopMode = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] lastRd;
  logic hreadyout, hresp, fastClock, slowClock, periphResetN, stopHold;
  logic warmupDoneIrq, fastOscEnable, slowOscEnable;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int irqCount = 0;

  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (warmupDoneIrq === 1'b1)
      irqCount <= irqCount + 1;
  end

  owc_warmup_counter u_dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fastClock(fastClock),
    .slowClock(slowClock), .stopMode(stopMode), .periphResetN(periphResetN),
    .stopHold(stopHold), .warmupDoneIrq(warmupDoneIrq), .fastOscEnable(fastOscEnable),
    .slowOscEnable(slowOscEnable));
  owc_osc_model u_osc (.clock(clock), .fastEn(fastOscEnable), .slowEn(slowOscEnable),
    .fastClock(fastClock), .slowClock(slowClock));

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function logic [31:0] near(input int a, input int e, input int tol);
    return {31'h0, a > e - tol && a < e + tol};
  endfunction

  // waits for hready sampled high, keeping the read data of that cycle
  task waitReady;
    logic rdy;
    do
    begin
      @(negedge clock);
      rdy = hreadyout;
      lastRd = hrdata;
      @(posedge clock);
    end
    while (rdy !== 1'b1);
  endtask

  task busAccess(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
  endtask

  // sel 0 core reset released, 1 interrupt, 2 stop hold dropped
  task waitFor(input int sel, input int lim, output int took);
    int t0;
    logic hit;
    t0 = cyc;
    hit = 1'b0;
    while (!hit && cyc - t0 < lim)
    begin
      @(negedge clock);
      hit = sel == 0 ? periphResetN === 1'b1 : sel == 1 ? warmupDoneIrq === 1'b1 :
        stopHold === 1'b0;
    end
    took = cyc - t0;
    check("waitDone", {31'h0, hit}, 32'h1);
    @(posedge clock);
  endtask

  initial
  begin
    #1000000;
    n_fail++;
    $display("watchdog expired");
    conclude();
  end

  initial
  begin
    logic [31:0] rd;
    int took, cmp, src, rel;
    void'($urandom(65));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rel = cyc;
    @(posedge clock);
    busAccess(OFF_CTRL, 1'b0, 32'h0); check("ctrlReset", lastRd, 32'h6);
    busAccess(OFF_CMP, 1'b0, 32'h0); check("cmpReset", lastRd, 32'h66);
    busAccess(OFF_STAT, 1'b0, 32'h0); check("statWarm", lastRd & 32'hF, 32'h1);
    // lower compare keeps the reset warm-up within the run budget
    busAccess(OFF_CMP, 1'b1, 32'h20);
    waitFor(0, 60000, took);
    check("resetTime", near(cyc - rel, 32 * 512 * 3, 40), 32'h1);
    busAccess(OFF_STAT, 1'b0, 32'h0); check("statIdle", lastRd, 32'h8);
    for (int i = 0; i < 4; i++)
    begin
      cmp = 1 + $urandom % 2;
      src = $urandom % 2;
      busAccess(OFF_CTRL, 1'b1, 32'(src + 2 * i));
      busAccess(OFF_CMP, 1'b1, 32'(cmp));
      busAccess(OFF_OSC, 1'b1, 32'h1);
      busAccess(OFF_OSC, 1'b1, 32'h3);
      waitFor(1, 20000, took);
      rd = near(took, cmp * 64 * (1 << i) * (src ? 6 : 3), (1 << i) * 6 + 12);
      check("swTime", rd, 32'h1);
      busAccess(OFF_STAT, 1'b0, 32'h0); check("swDone", lastRd, 32'h8);
      check("irqCount", 32'(irqCount), 32'(i + 1));
    end
    busAccess(OFF_OSC, 1'b1, 32'h3);
    repeat (20) @(posedge clock);
    busAccess(OFF_STAT, 1'b0, 32'h0); check("noRestart", lastRd, 32'h8);
    busAccess(OFF_CMP, 1'b1, 32'hFF);
    busAccess(OFF_OSC, 1'b1, 32'h1);
    busAccess(OFF_OSC, 1'b1, 32'h3);
    repeat (50) @(posedge clock);
    busAccess(OFF_STAT, 1'b0, 32'h0); check("swRun", lastRd & 32'h7, 32'h3);
    busAccess(OFF_CTRL, 1'b1, 32'hE);
    busAccess(OFF_STAT, 1'b0, 32'h0); check("abortIdle", lastRd, 32'h8);
    busAccess(OFF_CTRL, 1'b0, 32'h0); check("abortClear", lastRd, 32'h6);
    busAccess(OFF_OSC, 1'b0, 32'h0); check("abortKeep", lastRd, 32'h3);
    check("abortNoIrq", 32'(irqCount), 32'h4);
    busAccess(OFF_CTRL, 1'b1, 32'h0);
    busAccess(OFF_CMP, 1'b1, 32'h2);
    busAccess(OFF_OSC, 1'b1, 32'h1);
    busAccess(OFF_OSC, 1'b1, 32'h3);
    repeat (100) @(posedge clock);
    stopMode <= 1'b1;
    repeat (10) @(posedge clock);
    busAccess(OFF_STAT, 1'b0, 32'h0);
    rd = lastRd;
    repeat (40) @(posedge clock);
    busAccess(OFF_STAT, 1'b0, 32'h0); check("stopFreeze", lastRd, rd);
    stopMode <= 1'b0;
    waitFor(1, 2000, took);
    busAccess(OFF_STAT, 1'b0, 32'h0); check("resumeIdle", lastRd, 32'h8);
    check("resumeDone", 32'(irqCount), 32'h5);
    for (int s = 0; s < 2; s++)
    begin
      busAccess(OFF_OSC, 1'b1, 32'(3 + 4 * s));
      busAccess(OFF_CTRL, 1'b1, 32'(1 - s));
      busAccess(OFF_CMP, 1'b1, 32'h1);
      stopMode <= 1'b1;
      repeat (5) @(posedge clock);
      check("stopHoldSet", {31'h0, stopHold}, 32'h1);
      check("oscOff", {30'h0, fastOscEnable, slowOscEnable}, 32'h0);
      stopMode <= 1'b0;
      waitFor(2, 5000, took);
      check("stopTime", near(took, 64 * (s ? 6 : 3), 30), 32'h1);
    end
    busAccess(8'h10, 1'b1, 32'hFFFFFFFF);
    busAccess(8'h10, 1'b0, 32'h0); check("unmapped", lastRd, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    conclude();
  end
endmodule // oscillator_warmup_counter_tb

// *** tb/owc_osc_model.sv ***
// oscillator model: raw clocks that run only while enabled
`timescale 1ns/1ps
module owc_osc_model
(
  // system clock
  input wire logic clock,
  // enables from the block
  input wire logic fastEn,
  input wire logic slowEn,
  // raw oscillator outputs
  output logic fastClock,
  output logic slowClock
);
  int fastCnt = 0;
  int slowCnt = 0;
  initial fastClock = 1'b0;
  initial slowClock = 1'b0;
  // stopped oscillator holds low; fast period 3, slow period 6
  always @(posedge clock)
  begin
    fastCnt <= fastEn ? (fastCnt + 1) % 3 : 0;
    fastClock <= fastEn && fastCnt == 0;
    slowCnt <= slowEn ? (slowCnt + 1) % 6 : 0;
    slowClock <= slowEn && slowCnt < 3;
  end
endmodule // owc_osc_model
